// File: design/drp_repeater.sv
// ddc repeater top: pin sampling, enable logic, ahb-lite registers, two lines
//
// How it works
// - gated mode: enable is power AND path enable
// - bypass mode: enable follows path enable while the device is powered, source power ignored
// - power indicator comes from selected source port
// - path enable active high, undriven means enabled
// - drivers follow r side only while powered, enabled
// - r side low drives t side low
// - r side high releases t side
// - external t low drives r side low
// - t release frees r, t held until r rises
// - standard-mode traffic passes on both segments
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "drp_params.svh"

module drp_repeater #(
   parameter int N_SRC = 4,
   parameter int SEL_W = 2
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // ahb-lite slave
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic [31:0]           hrdata,
   output logic                  hresp,
   // configuration pins
   input  wire logic             pin_config_select,
   input  wire logic             path_enable,
   input  wire logic             path_enable_driven,
   input  wire logic [SEL_W-1:0] src_select,
   input  wire logic [N_SRC-1:0] source_power_indicator,
   input  wire logic             device_powered,
   // r side scl
   input  wire logic             r_scl_i,
   output logic                  r_scl_o,
   output logic                  r_scl_oe,
   // r side sda
   input  wire logic             r_sda_i,
   output logic                  r_sda_o,
   output logic                  r_sda_oe,
   // t side scl, reads low only when pulled below the low threshold
   input  wire logic             t_scl_i,
   output logic                  t_scl_o,
   output logic                  t_scl_oe,
   // t side sda, reads low only when pulled below the low threshold
   input  wire logic             t_sda_i,
   output logic                  t_sda_o,
   output logic                  t_sda_oe,
   // repeater enable seen by the drivers
   output logic                  repeater_en
);

   localparam int SW = 8 + N_SRC + SEL_W;
   localparam int PAD_CTRL = 32 - 2 - SEL_W;
   localparam int PAD_STATUS = 32 - 10;
   localparam int STD_CYC = `DRP_STD_PERIOD_NS / `DRP_CLK_PERIOD_NS;
   localparam int FWD_MAX = 2;

   // lines idle high and path enable defaults on until a pin drives it
   localparam logic [SW-1:0] SYNC_RST = {
      {4{1'h1}}, 1'h0, {N_SRC{1'h0}}, {SEL_W{1'h0}}, 1'h0, 1'h1, 1'h0
   };

   // address match used by the read and the write decode
   function automatic logic ofs_hit(input logic [31:0] a, input logic [7:0] ofs);
      return (a[7:0] == ofs) && (a[31:8] == 24'h0);
   endfunction

   // ------------------------------------------------------------------
   // pin sampling
   // ------------------------------------------------------------------
   logic [SW-1:0] sync_raw;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;

   // every input pin except clock, reset and the ahb-lite port crosses two flops before any logic looks at it
   assign sync_raw = {r_scl_i, r_sda_i, t_scl_i, t_sda_i, device_powered,
                      source_power_indicator, src_select, path_enable_driven,
                      path_enable, pin_config_select};

   // two-stage synchroniser; only stage two reads stage one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
      end else begin
         sync1_q <= sync_raw;
         sync2_q <= sync1_q;
      end
   end

   logic             gcs_s;
   logic             pen_s;
   logic             pen_drv_s;
   logic [SEL_W-1:0] sel_s;
   logic [N_SRC-1:0] pwr_s;
   logic             powered_s;
   logic             r_scl_s;
   logic             r_sda_s;
   logic             t_scl_s;
   logic             t_sda_s;

   // unpack the synchronised pins
   assign gcs_s     = sync2_q[0];
   assign pen_s     = sync2_q[1];
   assign pen_drv_s = sync2_q[2];
   assign sel_s     = sync2_q[3 +: SEL_W];
   assign pwr_s     = sync2_q[3 + SEL_W +: N_SRC];
   assign powered_s = sync2_q[3 + SEL_W + N_SRC];
   assign t_sda_s   = sync2_q[4 + SEL_W + N_SRC];
   assign t_scl_s   = sync2_q[5 + SEL_W + N_SRC];
   assign r_sda_s   = sync2_q[6 + SEL_W + N_SRC];
   assign r_scl_s   = sync2_q[7 + SEL_W + N_SRC];

   // ------------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------------
   logic             pgate_q;
   logic             pen_reg_q;
   logic [SEL_W-1:0] sel_reg_q;
   logic             en_q;

   // ------------------------------------------------------------------
   // enable logic
   // ------------------------------------------------------------------
   logic             pen_pin;
   logic             pen_eff;
   logic [SEL_W-1:0] sel_eff;
   logic             sel_pwr;
   logic             gate_on;
   logic             en_d;

   // a floating path enable pin reads as enabled, like a pull-up
   assign pen_pin = pen_drv_s ? pen_s : 1'h1;
   // pin select high: config from pins; low: config from registers
   assign pen_eff = gcs_s ? pen_pin : pen_reg_q;
   assign sel_eff = gcs_s ? sel_s : sel_reg_q;
   // power of whichever source port feeds this output
   assign sel_pwr = pwr_s[sel_eff];
   // power gating is forced on by the pin select, else taken from the register
   assign gate_on = gcs_s | pgate_q;
   // an unpowered device keeps both drivers off whatever the pins say
   assign en_d = powered_s & (gate_on ? (sel_pwr & pen_eff) : pen_eff);

   // registered enable keeps glitches from the select mux off the line machines
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_q <= 1'h0;
      end else begin
         en_q <= en_d;
      end
   end

   assign repeater_en = en_q;

   // ------------------------------------------------------------------
   // line channels
   // ------------------------------------------------------------------
   logic                scl_r_drive;
   logic                scl_t_drive;
   logic                sda_r_drive;
   logic                sda_t_drive;
   drp_pkg::drp_state_t scl_state;
   drp_pkg::drp_state_t sda_state;

   // t inputs only read low for a hard external pull, never for our own low
   drp_line u_scl (
      .clk     (clk),
      .rst     (rst),
      .en      (en_q),
      .r_low   (~r_scl_s),
      .t_low   (~t_scl_s),
      .r_drive (scl_r_drive),
      .t_drive (scl_t_drive),
      .state   (scl_state)
   );

   drp_line u_sda (
      .clk     (clk),
      .rst     (rst),
      .en      (en_q),
      .r_low   (~r_sda_s),
      .t_low   (~t_sda_s),
      .r_drive (sda_r_drive),
      .t_drive (sda_t_drive),
      .state   (sda_state)
   );

   // open drain: data always low, enable high while we pull the line
   assign r_scl_o  = 1'h0;
   assign r_sda_o  = 1'h0;
   assign t_scl_o  = 1'h0;
   assign t_sda_o  = 1'h0;
   assign r_scl_oe = scl_r_drive;
   assign r_sda_oe = sda_r_drive;
   assign t_scl_oe = scl_t_drive;
   assign t_sda_oe = sda_t_drive;

   // ------------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ------------------------------------------------------------------
   logic        ahb_take;
   logic        rd_take;
   logic        wr_take_ctrl;
   logic [31:0] rd_ctrl;
   logic [31:0] rd_status;
   logic [31:0] rd_mux;
   logic        wr_ctrl_q;
   logic [31:0] hrdata_q;

   // only single word transfers are expected, so hsize is not decoded
   assign ahb_take     = hsel & hready & htrans[`DRP_HTRANS_SEQ_BIT];
   assign rd_take      = ahb_take & ~hwrite;
   assign wr_take_ctrl = ahb_take & hwrite & ofs_hit(haddr, `DRP_OFS_CTRL);

   // read views; status is read only and unmapped words read zero
   assign rd_ctrl   = {{PAD_CTRL{1'h0}}, sel_reg_q, pen_reg_q, pgate_q};
   assign rd_status = {{PAD_STATUS{1'h0}}, sda_state, scl_state, sel_pwr, en_q};
   assign rd_mux    = ofs_hit(haddr, `DRP_OFS_CTRL)   ? rd_ctrl   :
                      ofs_hit(haddr, `DRP_OFS_STATUS) ? rd_status : 32'h0;

   // address phase: remember a control write, load read data for the data phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ctrl_q <= 1'h0;
         hrdata_q  <= 32'h0;
      end else begin
         wr_ctrl_q <= wr_take_ctrl;
         if (rd_take) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   // data phase: control fields take hwdata; status writes fall away
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pgate_q   <= `DRP_RST_PGATE;
         pen_reg_q <= `DRP_RST_PEN;
         sel_reg_q <= '0;
      end else if (wr_ctrl_q) begin
         pgate_q   <= hwdata[`DRP_CTRL_PGATE];
         pen_reg_q <= hwdata[`DRP_CTRL_PEN];
         sel_reg_q <= hwdata[`DRP_CTRL_SEL_LO +: SEL_W];
      end
   end

   assign hreadyout = 1'h1;
   assign hresp     = `DRP_HRESP_OKAY;
   assign hrdata    = hrdata_q;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_en_gated: assert property (
      gate_on |=> en_q == $past(powered_s && pwr_s[sel_eff] && pen_eff))
      else $error("enable not power and path enable in gated mode");

   chk_en_bypass: assert property (
      (!gcs_s && !pgate_q && powered_s) |=> en_q == $past(pen_eff))
      else $error("enable does not follow path enable in bypass mode");

   chk_sel_port: assert property (
      (gcs_s && powered_s && pen_pin && pwr_s == '0) |=> !en_q)
      else $error("enable high with no selected source powered");

   chk_pen_default: assert property (
      (gcs_s && !pen_drv_s && powered_s && sel_pwr) |=> en_q)
      else $error("undriven path enable did not enable");

   chk_off_quiet: assert property (
      !en_q |=> !(r_scl_oe || t_scl_oe || r_sda_oe || t_sda_oe))
      else $error("driver on while repeater disabled");

   chk_r_to_t: assert property (
      (en_q && en_d && !r_scl_s && scl_state == drp_pkg::st_idle) |=> t_scl_oe)
      else $error("r side low not forwarded to t side");

   chk_t_release: assert property (
      (en_q && en_d && scl_state == drp_pkg::st_r_low && r_scl_s && t_scl_s)
      |=> !t_scl_oe)
      else $error("t side held after r side rose");

   chk_t_to_r: assert property (
      (en_q && en_d && !t_sda_s) |=> r_sda_oe && t_sda_oe)
      else $error("external t low not forwarded to r side");

   chk_t_hold: assert property (
      (en_q && en_d && scl_state == drp_pkg::st_t_low && t_scl_s)
      |=> t_scl_oe && !r_scl_oe)
      else $error("wrong drivers after t side release");

   chk_no_echo: assert property (
      (en_q && en_d && sda_state == drp_pkg::st_t_rel && t_sda_s) |=> !r_sda_oe)
      else $error("own low echoed back to r side");

   chk_fwd_latency: assert property (
      (en_q && en_d && $fell(r_scl_s) && scl_state == drp_pkg::st_idle)
      |-> ##[1:FWD_MAX] t_scl_oe)
      else $error("r side low forwarded too late");

   // main scenarios
   cov_r_pulse: cover property (
      en_q && $fell(r_scl_s) ##[1:STD_CYC] $rose(r_scl_s));
   cov_t_stretch: cover property (
      sda_state == drp_pkg::st_t_low ##1 sda_state == drp_pkg::st_t_rel
      ##[1:FWD_MAX] sda_state == drp_pkg::st_idle);
   cov_bypass_en: cover property (!gate_on && en_q && !sel_pwr);
   cov_ctrl_write: cover property (wr_take_ctrl ##1 wr_ctrl_q);

endmodule

// File: design/drp_params.svh
// register map, field positions, reset values and timing of the ddc repeater
`ifndef DRP_PARAMS_SVH
`define DRP_PARAMS_SVH

// register byte offsets, one aligned 32-bit word each
`define DRP_OFS_CTRL       8'h00
`define DRP_OFS_STATUS     8'h04

// control register fields
`define DRP_CTRL_PGATE     0
`define DRP_CTRL_PEN       1
`define DRP_CTRL_SEL_LO    2

// control register reset values
`define DRP_RST_PGATE      1'h1
`define DRP_RST_PEN        1'h1

// status register fields
`define DRP_ST_EN          0
`define DRP_ST_PWR         1
`define DRP_ST_SCL_LO      2
`define DRP_ST_SDA_LO      6

// ahb-lite encodings
`define DRP_HTRANS_SEQ_BIT 1
`define DRP_HRESP_OKAY     1'h0

// timing: system clock and standard-mode bus period
`define DRP_CLK_PERIOD_NS  10
`define DRP_STD_PERIOD_NS  10000

`endif

// File: design/drp_pkg.sv
// types shared by the ddc repeater design
package drp_pkg;

   // per-line state: which side started the current low
   typedef enum logic [3:0] {
      st_idle  = 4'h1,
      st_r_low = 4'h2,
      st_t_low = 4'h4,
      st_t_rel = 4'h8
   } drp_state_t;

endpackage

// File: design/drp_line.sv
// one repeated open-drain line (scl or sda) between the r and t segments
`timescale 1ns/1ps

module drp_line (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // repeater enable
   input  wire logic          en,
   // sampled levels, high means the line reads low
   input  wire logic          r_low,
   input  wire logic          t_low,
   // drivers, high pulls the line low
   output logic               r_drive,
   output logic               t_drive,
   output drp_pkg::drp_state_t state
);

   drp_pkg::drp_state_t state_q;
   drp_pkg::drp_state_t state_d;

   // next state: the origin of each low is remembered so our own low never echoes back
   always_comb begin
      state_d = state_q;
      if (!en) begin
         state_d = drp_pkg::st_idle;
      end else begin
         unique case (state_q)
            drp_pkg::st_idle: begin
               // an external t low wins: it drives both sides, which also covers an r low
               if (t_low) begin
                  state_d = drp_pkg::st_t_low;
               end else if (r_low) begin
                  state_d = drp_pkg::st_r_low;
               end
            end
            drp_pkg::st_r_low: begin
               if (t_low) begin
                  state_d = drp_pkg::st_t_low;
               end else if (!r_low) begin
                  state_d = drp_pkg::st_idle;
               end
            end
            drp_pkg::st_t_low: begin
               // r reads low here from our own drive, so only t decides
               if (!t_low) begin
                  state_d = drp_pkg::st_t_rel;
               end
            end
            drp_pkg::st_t_rel: begin
               // r may still read low for a few cycles from our released drive
               if (t_low) begin
                  state_d = drp_pkg::st_t_low;
               end else if (!r_low) begin
                  state_d = drp_pkg::st_idle;
               end
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= drp_pkg::st_idle;
      end else begin
         state_q <= state_d;
      end
   end

   // drivers decode straight from the one-hot state flops
   assign r_drive = (state_q == drp_pkg::st_t_low);
   assign t_drive = (state_q != drp_pkg::st_idle);
   assign state   = state_q;

endmodule

// File: verification/drp_far_side.sv
// far-side parties of the repeater: r-side master with a framed clock, t-side slave, wires
`timescale 1ns/1ps

module drp_far_side (
   // test controls
   input  wire logic scl_run,
   input  wire logic r_scl_hold,
   input  wire logic t_scl_hold,
   input  wire logic t_sda_hold,
   // device pulls on the r side
   input  wire logic r_scl_oe,
   input  wire logic r_sda_oe,
   // resolved wire levels
   output logic      r_scl,
   output logic      r_sda,
   output logic      t_scl,
   output logic      t_sda
);
   logic m_low;

   // master clock stands released between frames; 1 ns skew keeps it off the sampling edge
   initial m_low = 1'b0;
   always begin
      @(posedge scl_run);
      #1;
      while (scl_run) begin
         m_low = 1'b1;
         #62.5;
         m_low = 1'b0;
         #62.5;
      end
   end

   // pulled-up r wires read low while any party pulls
   assign r_scl = ~(m_low | r_scl_hold | r_scl_oe);
   assign r_sda = ~r_sda_oe;
   // t comparator sees only external pulls below threshold, never the device's own low
   assign t_scl = ~t_scl_hold;
   assign t_sda = ~t_sda_hold;
endmodule

// File: verification/tb.sv
// self-checking bench for the ddc repeater: registers, enable logic and both lines
`timescale 1ns/1ps
`include "drp_params.svh"

module tb;
   logic        clk, rst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, src_select;
   logic [3:0]  source_power_indicator;
   logic        pin_config_select, path_enable, path_enable_driven, device_powered;
   logic        r_scl_i, r_sda_i, t_scl_i, t_sda_i, repeater_en;
   logic        r_scl_oe, r_sda_oe, t_scl_oe, t_sda_oe;
   logic        scl_run, r_scl_hold, t_scl_hold, t_sda_hold, counting, exp_en, t_oe_q;
   int          mismatches, checks, t_pulses, r_pulses;

   drp_repeater DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .pin_config_select(pin_config_select), .path_enable(path_enable),
      .path_enable_driven(path_enable_driven), .src_select(src_select),
      .source_power_indicator(source_power_indicator), .device_powered(device_powered),
      .r_scl_i(r_scl_i), .r_scl_o(), .r_scl_oe(r_scl_oe), .r_sda_i(r_sda_i), .r_sda_o(),
      .r_sda_oe(r_sda_oe), .t_scl_i(t_scl_i), .t_scl_o(), .t_scl_oe(t_scl_oe),
      .t_sda_i(t_sda_i), .t_sda_o(), .t_sda_oe(t_sda_oe), .repeater_en(repeater_en));

   drp_far_side far (.scl_run(scl_run), .r_scl_hold(r_scl_hold), .t_scl_hold(t_scl_hold),
      .t_sda_hold(t_sda_hold), .r_scl_oe(r_scl_oe), .r_sda_oe(r_sda_oe), .r_scl(r_scl_i),
      .r_sda(r_sda_i), .t_scl(t_scl_i), .t_sda(t_sda_i));

   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // counts t driver pulses and r driver-on cycles during a clocked frame
   always @(posedge clk) begin
      t_oe_q <= t_scl_oe;
      if (counting && t_scl_oe === 1'b1 && t_oe_q === 1'b0) t_pulses <= t_pulses + 1;
      if (counting && r_scl_oe === 1'b1) r_pulses <= r_pulses + 1;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic cmp_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // waits for hready high at a rising edge, bounded
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         mismatches++;
         $display("unexpected hready: expected 1, seen %b", hreadyout);
         tally_and_finish();
      end
   endtask

   // one ahb-lite single word transfer; read data taken at the data-phase edge
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      cmp_bit("hresp", `DRP_HRESP_OKAY, hresp);
   endtask

   task automatic settle();
      repeat (6) @(posedge clk);
   endtask

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      pin_config_select = 1'b1;
      path_enable = 1'b1;
      path_enable_driven = 1'b1;
      src_select = 2'h0;
      source_power_indicator = 4'hF;
      device_powered = 1'b1;
      scl_run = 1'b0;
      r_scl_hold = 1'b0;
      t_scl_hold = 1'b0;
      t_sda_hold = 1'b0;
      counting = 1'b0;
      mismatches = 0;
      checks = 0;
      t_pulses = 0;
      r_pulses = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      ahb(1'b0, {24'h0, `DRP_OFS_CTRL}, 32'h0);
      cmp_word("ctrl reset", 32'h3, rd);
      ahb(1'b0, 32'h8, 32'h0);
      cmp_word("unmapped read", 32'h0, rd);
      ahb(1'b1, {24'h0, `DRP_OFS_STATUS}, 32'hFFFFFFFF);
      settle();
      ahb(1'b0, {24'h0, `DRP_OFS_STATUS}, 32'h0);
      cmp_word("status idle", 32'h47, rd);
      // sixteen select, gating, power and path enable cases; power only on the selected port or on every port but the selected one
      // in register mode the pins point elsewhere, so a wrong source mux shows up
      for (int i = 0; i < 16; i++) begin
         ahb(1'b1, {24'h0, `DRP_OFS_CTRL}, {28'h0, 2'(i % 4), i[0], i[2]});
         pin_config_select <= i[3];
         path_enable <= i[0] ^ ~i[3];
         src_select <= 2'(i % 4) ^ {2{~i[3]}};
         source_power_indicator <= i[1] ? (4'h1 << (i % 4)) : ~(4'h1 << (i % 4));
         settle();
         exp_en = (i[3] | i[2]) ? (i[1] & i[0]) : i[0];
         cmp_bit("repeater_en", exp_en, repeater_en);
         ahb(1'b0, {24'h0, `DRP_OFS_STATUS}, 32'h0);
         cmp_word("status en pwr", {30'h0, i[1], exp_en}, rd & 32'h3);
      end
      // no source port powered at all must keep the repeater off in gated mode
      source_power_indicator <= 4'h0;
      settle();
      cmp_bit("no source powered", 1'b0, repeater_en);
      pin_config_select <= 1'b1;
      source_power_indicator <= 4'hF;
      path_enable_driven <= 1'b0;
      path_enable <= 1'b0;
      settle();
      cmp_bit("floating path enable", 1'b1, repeater_en);
      path_enable_driven <= 1'b1;
      settle();
      cmp_bit("driven low path enable", 1'b0, repeater_en);
      t_sda_hold <= 1'b1;
      settle();
      cmp_bit("r_sda_oe disabled", 1'b0, r_sda_oe);
      t_sda_hold <= 1'b0;
      path_enable <= 1'b1;
      device_powered <= 1'b0;
      r_scl_hold <= 1'b1;
      settle();
      cmp_bit("t_scl_oe unpowered", 1'b0, t_scl_oe);
      r_scl_hold <= 1'b0;
      device_powered <= 1'b1;
      settle();
      r_scl_hold <= 1'b1;
      settle();
      cmp_bit("t_scl_oe r low", 1'b1, t_scl_oe);
      cmp_bit("r_scl_oe r low", 1'b0, r_scl_oe);
      t_scl_hold <= 1'b1;
      settle();
      cmp_bit("r_scl_oe both low", 1'b1, r_scl_oe);
      t_scl_hold <= 1'b0;
      r_scl_hold <= 1'b0;
      repeat (2) settle();
      cmp_bit("t_scl_oe r high", 1'b0, t_scl_oe);
      cmp_bit("r_scl_oe released", 1'b0, r_scl_oe);
      t_sda_hold <= 1'b1;
      settle();
      cmp_bit("r_sda_oe t low", 1'b1, r_sda_oe);
      cmp_bit("t_sda_oe t low", 1'b1, t_sda_oe);
      ahb(1'b0, {24'h0, `DRP_OFS_STATUS}, 32'h0);
      cmp_word("sda state t low", 32'h4 << `DRP_ST_SDA_LO, rd & 32'h3C0);
      t_sda_hold <= 1'b0;
      settle();
      cmp_bit("r_sda_oe t released", 1'b0, r_sda_oe);
      settle();
      cmp_bit("t_sda_oe r risen", 1'b0, t_sda_oe);
      // a clocked frame of eight periods; path enable stays put while it runs
      counting <= 1'b1;
      scl_run <= 1'b1;
      repeat (100) @(posedge clk);
      scl_run <= 1'b0;
      repeat (20) @(posedge clk);
      counting <= 1'b0;
      @(posedge clk);
      cmp_word("t_scl pulses", 32'd8, 32'(t_pulses));
      cmp_word("r_scl echo", 32'd0, 32'(r_pulses));
      tally_and_finish();
   end
endmodule
